// ==== sfa_pkg.sv ====
/*
 Shared constants of the secure fetch address path: register offsets,
 control and descriptor fields, AXI encodings, walker states, helpers.
 Assumes a 32-bit Avalon-MM register bus and a 32-bit AXI read channel.
*/
package sfa_pkg;
	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_TTB_S = 5'h04;
	localparam logic [4:0] A_TTB_NS = 5'h08;
	localparam logic [4:0] A_XVA = 5'h0C;
	localparam logic [4:0] A_XRES = 5'h10;
	localparam logic [4:0] A_RAW = 5'h14;
	localparam logic [4:0] A_VIEW = 5'h18;
	localparam logic [4:0] A_STAT = 5'h1C;
	// ------------------------------------------------------------
	// Control, status and translate result fields
	// ------------------------------------------------------------
	localparam int CTL_NS = 0;
	localparam int CTL_BE = 1;
	localparam int CTL_TFL = 2;
	localparam int CTL_IFL = 3;
	localparam int CTL_MODE = 4;
	localparam int MODE_W = 5;
	localparam logic [4:0] MODE_SVC = 5'h13;
	localparam logic [4:0] MODE_USR = 5'h10;
	localparam int XR_FAULT = 0;
	localparam int XR_NS = 1;
	localparam int ST_PEND = 3;
	// ------------------------------------------------------------
	// Descriptor layout and address splits
	// ------------------------------------------------------------
	localparam int D_TYPE = 0;
	localparam int D_NS = 3;
	localparam int D_XN = 4;
	localparam int D_USER = 5;
	localparam int D_CB = 6;
	localparam int D_SHR = 8;
	localparam logic [1:0] T_FAULT = 2'h0;
	localparam logic [1:0] T_TABLE = 2'h1;
	localparam logic [1:0] T_SECT = 2'h2;
	localparam logic [1:0] T_RSVD = 2'h3;
	localparam logic [1:0] CB_NC = 2'h0;
	localparam logic [1:0] CB_WB = 2'h3;
	localparam int PAGE_LSB = 12;
	localparam int SECT_LSB = 20;
	localparam int L2T_LSB = 10;
	localparam int TTB_LSB = 14;
	localparam int WORD_LSB = 2;
	// ------------------------------------------------------------
	// AXI encodings
	// ------------------------------------------------------------
	localparam int PROT_PRIV = 0;
	localparam int PROT_NS = 1;
	localparam int PROT_INSTR = 2;
	localparam logic [7:0] AR_LEN = 8'h00;
	localparam logic [2:0] AR_SIZE = 3'h2;
	localparam logic [1:0] AR_BURST = 2'h1;
	localparam logic [3:0] AR_C_DEV = 4'h0;
	localparam logic [3:0] AR_C_WB = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'h0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_CHECK = 3'h1,
		ST_L1_AR = 3'h2,
		ST_L1_R = 3'h3,
		ST_L2_AR = 3'h4,
		ST_L2_R = 3'h5,
		ST_FILL_AR = 3'h6,
		ST_FILL_R = 3'h7
	} sfa_state_t;

	function automatic logic [31:0] bswap(input logic [31:0] w);
		return {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [2:0] mkprot(input logic instr,
		input logic ns, input logic priv);
		logic [2:0] p;
		p = '0;
		p[PROT_INSTR] = instr;
		p[PROT_NS] = ns;
		p[PROT_PRIV] = priv;
		return p;
	endfunction
endpackage

// ==== sfa_tlb.sv ====
/*
 Fully associative translation buffer with round-robin refill.
 Assumes one writer, lookups combinational, N of at least two.
*/
`timescale 1ns/10ps
module sfa_tlb #(
	parameter int N = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic flush,
	input wire logic [19:0] lk_vpn,
	input wire logic lk_tns,
	output logic hit,
	output logic [19:0] ppn,
	output logic ns,
	output logic xn,
	output logic user,
	output logic cache,
	input wire logic wr_en,
	input wire logic [19:0] wr_vpn,
	input wire logic wr_tns,
	input wire logic [19:0] wr_ppn,
	input wire logic wr_ns,
	input wire logic wr_xn,
	input wire logic wr_user,
	input wire logic wr_cache
);
	localparam int IW = $clog2(N);
	logic [N-1:0] vld_r;
	logic [IW-1:0] vic_r;
	logic [19:0] vpn_m [N];
	logic [19:0] ppn_m [N];
	logic [3:0] att_m [N];
	logic [N-1:0] tns_m;
	logic [3:0] att;

	// Entries carry the requesting security state so both worlds coexist
	always_comb begin
		hit = 1'b0;
		ppn = '0;
		att = '0;
		for (int i = 0; i < N; i++) begin
			if (vld_r[i] && vpn_m[i] == lk_vpn && tns_m[i] == lk_tns) begin
				hit = 1'b1;
				ppn = ppn_m[i];
				att = att_m[i];
			end
		end
	end
	assign {cache, user, xn, ns} = att;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			vld_r <= '0;
			vic_r <= '0;
		end else if (flush) begin
			vld_r <= '0;
		end else if (wr_en) begin
			vld_r[vic_r] <= 1'b1;
			vic_r <= (vic_r == IW'(N - 1)) ? '0 : vic_r + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (wr_en) begin
			vpn_m[vic_r] <= wr_vpn;
			ppn_m[vic_r] <= wr_ppn;
			tns_m[vic_r] <= wr_tns;
			att_m[vic_r] <= {wr_cache, wr_user, wr_xn, wr_ns};
		end
	end
endmodule // sfa_tlb

// ==== sfa_icache.sv ====
/*
 Direct mapped one-word-line instruction cache, indexed by virtual
 address bits below the page offset and tagged by security and page.
 Assumes IDX_W plus two does not exceed the page offset width.
*/
`timescale 1ns/10ps
module sfa_icache #(
	parameter int IDX_W = 8,
	parameter int TAG_W = 21
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic flush,
	input wire logic [IDX_W-1:0] rd_idx,
	input wire logic [TAG_W-1:0] rd_tag,
	output logic hit,
	output logic [31:0] rd_data,
	input wire logic wr_en,
	input wire logic [IDX_W-1:0] wr_idx,
	input wire logic [TAG_W-1:0] wr_tag,
	input wire logic [31:0] wr_data
);
	localparam int LINES = 1 << IDX_W;
	logic [LINES-1:0] vld_r;
	logic [TAG_W-1:0] tag_m [LINES];
	logic [31:0] dat_m [LINES];

	// Index lies inside the page offset, so no alias can form
	assign hit = vld_r[rd_idx] && tag_m[rd_idx] == rd_tag;
	assign rd_data = dat_m[rd_idx];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) vld_r <= '0;
		else if (flush) vld_r <= '0;
		else if (wr_en) vld_r[wr_idx] <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (wr_en) begin
			tag_m[wr_idx] <= wr_tag;
			dat_m[wr_idx] <= wr_data;
		end
	end
endmodule // sfa_icache

// ==== sfa_fetch_path.sv ====
/*
 Top of the secure fetch address path: fetch port, translation buffer,
 virtually indexed instruction cache, two-level walker, single-beat AXI read
 master and Avalon-MM control registers.
 Assumes all masters and the AXI slave run on core_clk.
*/
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// - Reads issue without ordering against other traffic; weak order.
// - Shareable regions that are not write-back are never cached.
// - Reset leaves supervisor mode, secure state, security bit zero.
// - Memory is a byte array from zero; words sit at 0-3, 4-7.
// - Data words may be viewed big-endian or little-endian.
// - Fetched instructions are always little-endian.
// - No word-invariant big-endian mode exists.
// - Modified virtual address equals virtual address.
// - Non-secure state walks non-secure tables, yields non-secure addresses.
// - Secure state walks secure tables; descriptor bit sets security.
// - Data side uses physical addresses for index and tag.
// - Instruction cache: virtual index, physical tag.
// - Translation and cache lookup happen in the same cycle.
// - Each fetch uses descriptors of the current security state.
// - No abort, tag hit and cacheable page: cached instruction returns to core.
// - Cache miss sends the physical address out on AXI.
// - Non-secure state marks every external access non-secure.
// - Secure state marks fills by the descriptor security bit.
// - Secure state walks both levels as secure accesses.
module sfa_fetch_path #(
	parameter int TLB_N = 8,
	parameter int IC_IDX_W = 8
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic fetch_req,
	input wire logic [31:0] fetch_va,
	output logic fetch_ready,
	output logic fetch_valid,
	output logic [31:0] fetch_instr,
	output logic fetch_abort,
	output logic arvalid,
	input wire logic arready,
	output logic [31:0] araddr,
	output logic [2:0] arprot,
	output logic [7:0] arlen,
	output logic [2:0] arsize,
	output logic [1:0] arburst,
	output logic [3:0] arcache,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	localparam int PL = sfa_pkg::PAGE_LSB;
	localparam int SL = sfa_pkg::SECT_LSB;
	localparam int WL = sfa_pkg::WORD_LSB;

	sfa_pkg::sfa_state_t st_r, st_nxt;
	logic ack_r, first_r, ns_state_r, data_be_r, xpend_r, is_x_r;
	logic req_ns_r, l1ns_r, ar_c_r;
	logic [4:0] mode_r;
	logic [2:0] ar_prot_r;
	logic [31:0] ttb_s_r, ttb_ns_r, raw_r, xva_r, xres_r, va_r, ar_addr_r;
	logic [31:0] ctrl_val, rd_val, wmix, ttb_sel;
	logic acc, wr_go, tlb_flush, ic_flush, take_f, take_x;
	logic t_hit, t_ns, t_xn, t_user, t_cache, ic_hit, prot_flt;
	logic [19:0] t_ppn, tw_ppn;
	logic [31:0] ic_data;
	logic [1:0] d_type, d_cb;
	logic r_ok, walk_flt, tw_en, tw_ns, tw_cache, ic_we, in_l1, is_tab;

	// ------------------------------------------------------------
	// Avalon-MM slave: one wait state, answer on the second edge
	// ------------------------------------------------------------
	assign acc = avs_read | avs_write;
	assign avs_waitrequest = acc & ~ack_r;
	assign wr_go = avs_write & ack_r;
	assign wmix = sfa_pkg::wmerge(rd_val, avs_writedata, avs_byteenable);

	always_comb begin
		ctrl_val = '0;
		ctrl_val[sfa_pkg::CTL_NS] = ns_state_r;
		ctrl_val[sfa_pkg::CTL_BE] = data_be_r;
		ctrl_val[sfa_pkg::CTL_MODE +: sfa_pkg::MODE_W] = mode_r;
	end

	always_comb begin
		case (avs_address)
		sfa_pkg::A_CTRL: rd_val = ctrl_val;
		sfa_pkg::A_TTB_S: rd_val = ttb_s_r;
		sfa_pkg::A_TTB_NS: rd_val = ttb_ns_r;
		sfa_pkg::A_XVA: rd_val = xva_r;
		sfa_pkg::A_XRES: rd_val = xres_r;
		sfa_pkg::A_RAW: rd_val = raw_r;
		// Byte order applies to data only, one bit wide
		sfa_pkg::A_VIEW: rd_val = data_be_r ? sfa_pkg::bswap(raw_r) : raw_r;
		sfa_pkg::A_STAT: rd_val = {28'h0, xpend_r, st_r};
		default: rd_val = '0;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ack_r <= 1'b0;
			avs_readdata <= '0;
		end else begin
			ack_r <= acc & ~ack_r;
			if (avs_read & ~ack_r) avs_readdata <= rd_val;
		end
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ns_state_r <= 1'b0;
			mode_r <= sfa_pkg::MODE_SVC;
			data_be_r <= 1'b0;
		end else if (wr_go && avs_address == sfa_pkg::A_CTRL) begin
			ns_state_r <= wmix[sfa_pkg::CTL_NS];
			// No word-invariant mode: one bit picks the order
			data_be_r <= wmix[sfa_pkg::CTL_BE];
			mode_r <= wmix[sfa_pkg::CTL_MODE +: sfa_pkg::MODE_W];
		end
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ttb_s_r <= '0;
			ttb_ns_r <= '0;
			raw_r <= '0;
			xva_r <= '0;
		end else if (wr_go) begin
			if (avs_address == sfa_pkg::A_TTB_S) ttb_s_r <= wmix;
			if (avs_address == sfa_pkg::A_TTB_NS) ttb_ns_r <= wmix;
			if (avs_address == sfa_pkg::A_RAW) raw_r <= wmix;
			if (avs_address == sfa_pkg::A_XVA) xva_r <= wmix;
		end
	end

	// New table base invalidates cached translations
	assign tlb_flush = wr_go && ((avs_address == sfa_pkg::A_CTRL &&
		wmix[sfa_pkg::CTL_TFL]) || avs_address == sfa_pkg::A_TTB_S ||
		avs_address == sfa_pkg::A_TTB_NS);
	assign ic_flush = wr_go && avs_address == sfa_pkg::A_CTRL &&
		wmix[sfa_pkg::CTL_IFL];

	// A write in the cycle the walker takes the old one stays pending
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) xpend_r <= 1'b0;
		else if (wr_go && avs_address == sfa_pkg::A_XVA) xpend_r <= 1'b1;
		else if (take_x) xpend_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Request intake
	// ------------------------------------------------------------
	assign fetch_ready = st_r == sfa_pkg::ST_IDLE;
	assign take_f = fetch_ready & fetch_req;
	assign take_x = fetch_ready & ~fetch_req & xpend_r;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			va_r <= '0;
			is_x_r <= 1'b0;
			req_ns_r <= 1'b0;
		end else if (take_f | take_x) begin
			va_r <= take_f ? fetch_va : xva_r;
			is_x_r <= take_x;
			req_ns_r <= ns_state_r;
		end
	end

	// ------------------------------------------------------------
	// Parallel lookup
	// ------------------------------------------------------------
	sfa_tlb #(.N(TLB_N)) u_tlb (
		.clk(core_clk),
		.rstn(rstn),
		.flush(tlb_flush),
		.lk_vpn(va_r[31:PL]),
		.lk_tns(req_ns_r),
		.hit(t_hit),
		.ppn(t_ppn),
		.ns(t_ns),
		.xn(t_xn),
		.user(t_user),
		.cache(t_cache),
		.wr_en(tw_en),
		.wr_vpn(va_r[31:PL]),
		.wr_tns(req_ns_r),
		.wr_ppn(tw_ppn),
		.wr_ns(tw_ns),
		.wr_xn(rdata[sfa_pkg::D_XN]),
		.wr_user(rdata[sfa_pkg::D_USER]),
		.wr_cache(tw_cache)
	);

	// Same cycle: translation and virtually indexed read
	sfa_icache #(.IDX_W(IC_IDX_W)) u_icache (
		.clk(core_clk),
		.rstn(rstn),
		.flush(ic_flush),
		.rd_idx(va_r[IC_IDX_W+WL-1:WL]),
		.rd_tag({t_ns, t_ppn}),
		.hit(ic_hit),
		.rd_data(ic_data),
		.wr_en(ic_we),
		.wr_idx(va_r[IC_IDX_W+WL-1:WL]),
		.wr_tag({ar_prot_r[sfa_pkg::PROT_NS], ar_addr_r[31:PL]}),
		.wr_data(rdata)
	);

	assign prot_flt = (t_xn & ~is_x_r) |
		(mode_r == sfa_pkg::MODE_USR & ~t_user);

	// ------------------------------------------------------------
	// Walk descriptor decode
	// ------------------------------------------------------------
	assign in_l1 = st_r == sfa_pkg::ST_L1_R;
	assign d_type = rdata[sfa_pkg::D_TYPE +: 2];
	assign d_cb = rdata[sfa_pkg::D_CB +: 2];
	assign r_ok = rresp == sfa_pkg::RESP_OKAY;
	assign is_tab = in_l1 && d_type == sfa_pkg::T_TABLE;
	assign walk_flt = ~r_ok | d_type == sfa_pkg::T_FAULT |
		(in_l1 & d_type == sfa_pkg::T_RSVD);
	assign tw_en = rvalid & ~walk_flt &
		((in_l1 & d_type == sfa_pkg::T_SECT) | st_r == sfa_pkg::ST_L2_R);
	assign tw_ppn = in_l1 ? {rdata[31:SL], va_r[SL-1:PL]} : rdata[31:PL];
	// Non-secure requests never map to secure memory
	assign tw_ns = req_ns_r | (in_l1 ? rdata[sfa_pkg::D_NS] : l1ns_r);
	// Shareable but not write-back means uncached
	assign tw_cache = d_cb != sfa_pkg::CB_NC &&
		!(rdata[sfa_pkg::D_SHR] && d_cb != sfa_pkg::CB_WB);
	assign ttb_sel = req_ns_r ? ttb_ns_r : ttb_s_r;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) l1ns_r <= 1'b0;
		else if (is_tab & rvalid) l1ns_r <= rdata[sfa_pkg::D_NS];
	end

	// ------------------------------------------------------------
	// Walker and fill sequencing
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		case (st_r)
		sfa_pkg::ST_IDLE: begin
			if (take_f | take_x) st_nxt = sfa_pkg::ST_CHECK;
		end
		sfa_pkg::ST_CHECK: begin
			if (!t_hit) st_nxt = sfa_pkg::ST_L1_AR;
			else if (is_x_r | prot_flt) st_nxt = sfa_pkg::ST_IDLE;
			else if (ic_hit & t_cache) st_nxt = sfa_pkg::ST_IDLE;
			else st_nxt = sfa_pkg::ST_FILL_AR;
		end
		sfa_pkg::ST_L1_AR: begin
			if (arready) st_nxt = sfa_pkg::ST_L1_R;
		end
		sfa_pkg::ST_L1_R: begin
			if (rvalid & walk_flt) st_nxt = sfa_pkg::ST_IDLE;
			else if (rvalid & is_tab) st_nxt = sfa_pkg::ST_L2_AR;
			else if (rvalid) st_nxt = sfa_pkg::ST_CHECK;
		end
		sfa_pkg::ST_L2_AR: begin
			if (arready) st_nxt = sfa_pkg::ST_L2_R;
		end
		sfa_pkg::ST_L2_R: begin
			if (rvalid) st_nxt = walk_flt ? sfa_pkg::ST_IDLE : sfa_pkg::ST_CHECK;
		end
		sfa_pkg::ST_FILL_AR: begin
			if (arready) st_nxt = sfa_pkg::ST_FILL_R;
		end
		sfa_pkg::ST_FILL_R: begin
			if (rvalid) st_nxt = sfa_pkg::ST_IDLE;
		end
		default: st_nxt = sfa_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) st_r <= sfa_pkg::ST_IDLE;
		else st_r <= st_nxt;
	end

	// ------------------------------------------------------------
	// AXI read address, held from flops while valid is up
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ar_addr_r <= '0;
			ar_prot_r <= '0;
			ar_c_r <= 1'b0;
		end else if (st_r == sfa_pkg::ST_CHECK) begin
			ar_c_r <= t_cache;
			if (!t_hit) begin
				// Walks take the requester's state only
				ar_addr_r <= {ttb_sel[31:sfa_pkg::TTB_LSB], va_r[31:SL], 2'h0};
				ar_prot_r <= sfa_pkg::mkprot(1'b0, req_ns_r, 1'b1);
			end else begin
				// Byte address of the word holding the fetch
				ar_addr_r <= {t_ppn, va_r[PL-1:WL], 2'h0};
				ar_prot_r <= sfa_pkg::mkprot(1'b1, req_ns_r | t_ns,
					mode_r != sfa_pkg::MODE_USR);
			end
		end else if (is_tab & rvalid) begin
			ar_addr_r <= {rdata[31:sfa_pkg::L2T_LSB], va_r[SL-1:PL], 2'h0};
			ar_prot_r <= sfa_pkg::mkprot(1'b0, req_ns_r, 1'b1);
		end
	end

	// No fence waits on earlier traffic: order is weak
	assign arvalid = st_r == sfa_pkg::ST_L1_AR || st_r == sfa_pkg::ST_L2_AR ||
		st_r == sfa_pkg::ST_FILL_AR;
	assign rready = st_r == sfa_pkg::ST_L1_R || st_r == sfa_pkg::ST_L2_R ||
		st_r == sfa_pkg::ST_FILL_R;
	assign araddr = ar_addr_r;
	assign arprot = ar_prot_r;
	assign arlen = sfa_pkg::AR_LEN;
	assign arsize = sfa_pkg::AR_SIZE;
	assign arburst = sfa_pkg::AR_BURST;
	assign arcache = ar_c_r ? sfa_pkg::AR_C_WB : sfa_pkg::AR_C_DEV;
	assign ic_we = st_r == sfa_pkg::ST_FILL_R & rvalid & r_ok & ar_c_r;

	// ------------------------------------------------------------
	// Fetch answer
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			fetch_valid <= 1'b0;
			fetch_abort <= 1'b0;
			fetch_instr <= '0;
		end else begin
			fetch_valid <= 1'b0;
			fetch_abort <= 1'b0;
			if (!is_x_r) begin
				case (st_r)
				sfa_pkg::ST_CHECK: begin
					if (t_hit & prot_flt) begin
						fetch_abort <= 1'b1;
					end else if (t_hit & ic_hit & t_cache) begin
						fetch_valid <= 1'b1;
						fetch_instr <= ic_data;
					end
				end
				sfa_pkg::ST_L1_R, sfa_pkg::ST_L2_R: begin
					if (rvalid & walk_flt) fetch_abort <= 1'b1;
				end
				sfa_pkg::ST_FILL_R: begin
					if (rvalid & r_ok) begin
						fetch_valid <= 1'b1;
						// Instruction bytes ignore the data order
						fetch_instr <= rdata;
					end else if (rvalid) begin
						fetch_abort <= 1'b1;
					end
				end
				default: begin
				end
				endcase
			end
		end
	end

	// Translate result: data side indexes and tags by this address
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			xres_r <= '0;
		end else if (is_x_r && st_r == sfa_pkg::ST_CHECK && t_hit) begin
			xres_r <= {t_ppn, 12'h0};
			xres_r[sfa_pkg::XR_NS] <= t_ns;
			xres_r[sfa_pkg::XR_FAULT] <= prot_flt;
		end else if (is_x_r && rvalid && walk_flt &&
			(st_r == sfa_pkg::ST_L1_R || st_r == sfa_pkg::ST_L2_R)) begin
			xres_r <= '0;
			xres_r[sfa_pkg::XR_FAULT] <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) first_r <= 1'b1;
		else first_r <= 1'b0;
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	sequence s_chk;
		st_r == sfa_pkg::ST_CHECK && t_hit && !is_x_r;
	endsequence
	sequence s_hit;
		s_chk ##0 !prot_flt && ic_hit && t_cache;
	endsequence

	chk_reset_secure:
	assert property (first_r |-> !ns_state_r && mode_r == sfa_pkg::MODE_SVC)
		else $error("reset state not secure supervisor");
	chk_hit_return:
	assert property (s_hit |=> fetch_valid && fetch_instr == $past(ic_data))
		else $error("cached hit not returned");
	chk_miss_fill:
	assert property (s_chk ##0 !prot_flt && !(ic_hit && t_cache)
		|=> arvalid && araddr[31:PL] == $past(t_ppn))
		else $error("miss did not issue physical address");
	chk_ns_bus:
	assert property (arvalid && req_ns_r |-> arprot[sfa_pkg::PROT_NS])
		else $error("non-secure state access marked secure");
	chk_walk_secure:
	assert property (arvalid && !req_ns_r && st_r != sfa_pkg::ST_FILL_AR
		|-> !arprot[sfa_pkg::PROT_NS])
		else $error("secure walk marked non-secure");
	chk_abort_quiet:
	assert property (s_chk ##0 prot_flt
		|=> fetch_abort && !fetch_valid && !arvalid ##1 !arvalid)
		else $error("abort returned data or started access");
	chk_instr_le:
	assert property (st_r == sfa_pkg::ST_FILL_R && rvalid && r_ok && !is_x_r
		|=> fetch_valid && fetch_instr == $past(rdata))
		else $error("instruction bytes reordered");
	chk_view_order:
	assert property (avs_read && !avs_waitrequest &&
		avs_address == sfa_pkg::A_VIEW |-> avs_readdata ==
		(data_be_r ? sfa_pkg::bswap(raw_r) : raw_r))
		else $error("data view byte order wrong");
	chk_ns_entry:
	assert property (st_r == sfa_pkg::ST_CHECK && t_hit && req_ns_r |-> t_ns)
		else $error("non-secure lookup gave secure address");
	chk_nocache_shr:
	assert property (tw_en && rdata[sfa_pkg::D_SHR] && d_cb != sfa_pkg::CB_WB
		|=> st_r == sfa_pkg::ST_CHECK && !t_cache)
		else $error("shareable non-write-back region cached");
	chk_va_kept:
	assert property (take_f |=> va_r == $past(fetch_va))
		else $error("fetch address modified");
endmodule // sfa_fetch_path

// ==== sfa_mem_model.sv ====
/*
 AXI read memory model answering single beats after lat cycles.
 Assumes the bench fills mem and sets lat between fetches.
*/
`timescale 1ns/10ps
module sfa_mem_model (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [3:0] lat,
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata
);
	logic [31:0] mem [int];
	logic [3:0] cnt;
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			arready <= 1'b0;
			rvalid <= 1'b0;
			rdata <= 32'h0;
			cnt <= 4'h0;
		end else begin
			arready <= arvalid && !arready && !rvalid && cnt == lat;
			cnt <= (arvalid && !arready && cnt != lat) ? cnt + 4'h1 : 4'h0;
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= mem[araddr];
			end else if (rready) begin
				rvalid <= 1'b0;
				// Released word flips so stale data never looks valid
				rdata <= ~rdata;
			end
		end
	end
endmodule // sfa_mem_model

// ==== sfa_fetch_path_bench.sv ====
/*
 Self-checking bench for the fetch path: walks, fills, hits, abort.
 Assumes the memory model answers every read with OKAY.
*/
`timescale 1ns/10ps
module sfa_fetch_path_bench;
	logic core_clk, rstn, avs_read, avs_write, avs_waitrequest, fetch_req;
	logic fetch_ready, fetch_valid, fetch_abort, arvalid, arready, rvalid;
	logic rready;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, fetch_va, fetch_instr;
	logic [31:0] araddr, rdata, q;
	logic [2:0] arprot, arsize;
	logic [3:0] lat, arcache;
	logic [7:0] arlen;
	logic [1:0] arburst;
	logic [38:0] aq [$];
	localparam logic [12:0] AR_FIX = {sfa_pkg::AR_LEN, sfa_pkg::AR_SIZE,
		sfa_pkg::AR_BURST};
	int num_errors, tests_run, n;
	sfa_fetch_path dut (.core_clk, .rstn, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
		.avs_waitrequest, .fetch_req, .fetch_va, .fetch_ready, .fetch_valid,
		.fetch_instr, .fetch_abort, .arvalid, .arready, .araddr, .arprot,
		.arlen, .arsize, .arburst, .arcache, .rvalid, .rready,
		.rdata, .rresp(2'h0));
	sfa_mem_model mm (.clk(core_clk), .rstn, .lat, .arvalid, .arready,
		.araddr, .rvalid, .rready, .rdata);
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		if (arvalid && arready) begin
			aq.push_back({arcache, arprot, araddr});
			chk({arlen, arsize, arburst}, AR_FIX);
		end
	end
	task automatic give_verdict();
		$display("errors %0d of %0d checks", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [38:0] got, input logic [38:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tmo();
		if (n >= 200) begin
			num_errors++;
			give_verdict();
		end
	endtask
	// Request held until the edge where waitrequest is seen low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		for (n = 0; n < 200; n++) begin
			@(posedge core_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		// Data and waitrequest are taken as they stood at this edge
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		tmo();
	endtask
	task automatic fetch(input logic [31:0] va, input logic ab, input int nar);
		aq.delete();
		@(posedge core_clk);
		fetch_req <= 1'b1;
		fetch_va <= va;
		for (n = 0; n < 200 && fetch_ready !== 1'b1; n++) @(negedge core_clk);
		tmo();
		@(posedge core_clk);
		fetch_req <= 1'b0;
		for (n = 0; n < 200; n++) begin
			@(negedge core_clk);
			if (fetch_valid === 1'b1 || fetch_abort === 1'b1) break;
		end
		tmo();
		chk(fetch_abort, ab);
		if (!ab) chk(fetch_instr, 32'h11223344);
		chk(aq.size(), nar);
	endtask
	task automatic sc_secure();
		bus(1'b1, sfa_pkg::A_CTRL, 32'h132);
		lat <= 4'h3;
		fetch(32'h00400010, 1'b0, 2);
		chk(aq[0], {4'h0, 3'b001, 32'h00010010});
		chk(aq[1], {4'hF, 3'b111, 32'h80000010});
		lat <= 4'h0;
		fetch(32'h00400010, 1'b0, 0);
		chk(n, 1);
		// Status read lets the translation finish before its result is read
		bus(1'b1, sfa_pkg::A_XVA, 32'h00400010);
		bus(1'b0, sfa_pkg::A_STAT, 32'h0);
		bus(1'b0, sfa_pkg::A_XRES, 32'h0);
		chk(q, 32'h80000002);
		bus(1'b1, sfa_pkg::A_RAW, 32'h11223344);
		bus(1'b0, sfa_pkg::A_VIEW, 32'h0);
		chk(q, 32'h44332211);
		// Two-level walk whose first level is marked non-secure
		fetch(32'h00600020, 1'b0, 3);
		chk(aq[0], {4'h0, 3'b001, 32'h00010018});
		chk(aq[1], {4'h0, 3'b001, 32'h00030000});
		chk(aq[2], {4'hF, 3'b111, 32'h90000020});
	endtask
	task automatic sc_nonsecure();
		// Cache flush so the fill is not served by the secure-side line
		bus(1'b1, sfa_pkg::A_CTRL, 32'h13B);
		fetch(32'h00400010, 1'b0, 2);
		chk(aq[0], {4'h0, 3'b011, 32'h00020010});
		chk(aq[1], {4'hF, 3'b111, 32'h80000010});
		fetch(32'h00500000, 1'b1, 1);
	endtask
	initial begin
		{rstn, avs_read, avs_write, fetch_req} = 4'h0;
		{avs_address, avs_writedata, fetch_va, lat} = '0;
		mm.mem[32'h00010010] = 32'h800000CA;
		mm.mem[32'h00010018] = 32'h00030009;
		mm.mem[32'h00030000] = 32'h900000C2;
		mm.mem[32'h90000020] = 32'h11223344;
		mm.mem[32'h00020010] = 32'h800000C2;
		mm.mem[32'h00020014] = 32'h80000112;
		mm.mem[32'h80000010] = 32'h11223344;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		bus(1'b0, sfa_pkg::A_CTRL, 32'h0);
		chk(q, 32'h130);
		bus(1'b1, sfa_pkg::A_TTB_S, 32'h00010000);
		bus(1'b1, sfa_pkg::A_TTB_NS, 32'h00020000);
		sc_secure();
		sc_nonsecure();
		give_verdict();
	end
endmodule // sfa_fetch_path_bench
